// [inc/oaf_pkg.sv]
// Constants shared by the operand address formation block
package oaf_pkg;
   // Address geometry
   localparam int ADDR_W = 19;
   localparam int MOD_W = 5;
   localparam int FIELD_W = 24;
   localparam int CHAR_W = 6;
   localparam int WIDTH_W = 5;
   localparam logic [MOD_W-1:0] MOD_DIRECT = 5'h00;
   localparam logic [MOD_W-1:0] MOD_INDIRECT = 5'h10;
   localparam logic [WIDTH_W-1:0] WIDTH_32K = 5'h0F;
   localparam logic [WIDTH_W-1:0] WIDTH_64K = 5'h10;
   localparam logic [WIDTH_W-1:0] WIDTH_128K = 5'h11;
   localparam logic [WIDTH_W-1:0] WIDTH_256K = 5'h12;
   localparam logic [WIDTH_W-1:0] WIDTH_TOP = 5'h13;
   localparam logic [ADDR_W:0] CAP_32K = 20'h08000;
   localparam logic [ADDR_W:0] CAP_64K = 20'h10000;
   localparam logic [ADDR_W:0] CAP_128K = 20'h20000;
   // Index slot n ends at 4n; protected bank base is bank * 4096
   localparam int SLOT_SHIFT = 2;
   localparam int BANK_SHIFT = 12;
   localparam int BANK_W = 7;
   // Instruction formats
   localparam logic [1:0] FMT_AB = 2'h1;
   localparam logic [1:0] FMT_A = 2'h2;
   localparam logic [1:0] FMT_NONE = 2'h3;
   // APB register byte offsets
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_CAPACITY = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_A_ADDR = 8'h0C;
   localparam logic [7:0] REG_B_ADDR = 8'h10;
   localparam logic [7:0] REG_VARIANT = 8'h14;
   // Field positions
   localparam int CFG_PROTECT = 0;
   localparam int CFG_TOP_END = 1;
   localparam int CFG_BASIC = 2;
   localparam int CFG_BANK_LSB = 4;
   localparam int ST_VIOLATION = 0;
   localparam int ST_HALT = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_WIDTH_LSB = 4;
   // Reset values
   localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
   localparam logic [ADDR_W:0] CAPACITY_RST = 20'h40000;
   localparam logic [CHAR_W-1:0] VARIANT_CLEARED = 6'h00;
   typedef enum logic [2:0] {ST_IDLE, ST_A_FORM, ST_B_FORM, ST_FINISH} oaf_state_t;
endpackage : oaf_pkg

// [test/oaf_sva.sv]
// Port checks for operand address formation
`timescale 1ns/100ps
module oaf_sva
   import oaf_pkg::*;
(
   // Clock, reset and bus
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic o_pready,
   // Extraction
   input wire logic i_ext_valid,
   input wire logic [1:0] i_ext_format,
   input wire logic i_ext_dup_a,
   input wire logic [FIELD_W-1:0] i_ext_a_field,
   input wire logic [FIELD_W-1:0] i_ext_b_field,
   input wire logic o_ext_ready,
   input wire logic o_ext_done,
   // Results
   input wire logic [ADDR_W-1:0] o_a_operand_address_reg,
   input wire logic [ADDR_W-1:0] o_b_operand_address_reg,
   input wire logic o_halt,
   input wire logic o_address_violation_flag,
   input wire logic o_internal_interrupt
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   wire take = i_ext_valid && o_ext_ready;
   wire a_dir = i_ext_a_field[23:19] == MOD_DIRECT;
   wire both_dir = a_dir && i_ext_b_field[23:19] == MOD_DIRECT;
   wire stop = o_address_violation_flag || o_halt;
   a_bus_no_wait: assert property (i_psel && i_penable |-> o_pready)
      else $error("access without ready");
   a_fmt3_done: assert property (take && i_ext_format == FMT_NONE |-> ##2 o_ext_done)
      else $error("no-address format late");
   a_fmt3_hold: assert property (take && i_ext_format == FMT_NONE |=>
      ($stable(o_a_operand_address_reg) && $stable(o_b_operand_address_reg)) [*2])
      else $error("implicit format moved a register");
   a_dup_copy: assert property (take && i_ext_format == FMT_A && i_ext_dup_a && a_dir
      |-> ##3 (stop || o_a_operand_address_reg == o_b_operand_address_reg))
      else $error("duplicate A mismatch");
   a_keep_b: assert property (take && i_ext_format == FMT_A && !i_ext_dup_a
      |=> $stable(o_b_operand_address_reg) [*3])
      else $error("preserve B changed B");
   a_irq_flag: assert property (o_internal_interrupt |->
      o_address_violation_flag && o_ext_done)
      else $error("interrupt without flag");
   a_halt_blocks: assert property (o_halt |-> !o_ext_ready)
      else $error("ready while halted");
   a_halt_sticky: assert property (o_halt && !(i_psel && i_pwrite) |=> o_halt)
      else $error("halt dropped");
   a_fmt1_done: assert property (take && i_ext_format == FMT_AB && both_dir
      |-> ##4 (o_ext_done || stop))
      else $error("two-address format late");
   c_halt: cover property (o_halt);
   c_irq: cover property (o_internal_interrupt);
   c_dup: cover property (take && i_ext_format == FMT_A && i_ext_dup_a);
endmodule : oaf_sva

// [test/slot_memory.sv]
// Main memory model serving index slot reads
`timescale 1ns/100ps
module slot_memory (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // Slot read
   input wire logic i_rd,
   input wire logic [18:0] i_addr,
   input wire logic [1:0] i_wait,
   output logic o_valid = 1'b0,
   output logic [23:0] o_data = 24'h0
);
   logic [1:0] cnt = 2'h0;
   // Slots are only read, never written back
   function automatic logic [23:0] slot_value(input logic [18:0] a);
      return {5'h1F, a * 19'd7 + 19'd900};
   endfunction : slot_value
   // Idle data toggles so a stale value never looks valid
   always @(posedge i_mclk) begin
      if (i_srst || !i_rd || o_valid) begin
         cnt <= 2'h0;
         o_valid <= 1'b0;
         o_data <= ~o_data;
      end else if (cnt == i_wait) begin
         o_valid <= 1'b1;
         o_data <= slot_value(i_addr);
      end else begin
         cnt <= cnt + 2'h1;
         o_data <= ~o_data;
      end
   end
endmodule : slot_memory

// [test/test_operand_address_formation.sv]
// Bench for operand address formation with a slot memory model
`timescale 1ns/100ps
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
$display("unexpected %0t: got %h want %h", $time, g, e); end end
module test_operand_address_formation;
   import oaf_pkg::*;
   logic i_mclk = 1'b0;
   logic i_srst = 1'b1;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, o_pready, o_pslverr, rerr, irq;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rdata;
   logic i_ext_valid = 1'b0, i_ext_dup_a = 1'b0, i_ext_has_variant = 1'b0;
   logic i_ext_variant_exception = 1'b0, o_ext_ready, o_ext_done, o_slot_rd, i_slot_valid;
   logic [1:0] i_ext_format = FMT_NONE, slot_wait = 2'h0;
   logic [FIELD_W-1:0] i_ext_a_field = '0, i_ext_b_field = '0, i_slot_data;
   logic [CHAR_W-1:0] i_ext_variant = '0, o_variant_reg;
   logic o_halt, o_address_violation_flag, o_internal_interrupt;
   logic [ADDR_W-1:0] o_slot_addr, o_a_operand_address_reg, o_b_operand_address_reg;
   wire [43:0] regs = {o_a_operand_address_reg, o_b_operand_address_reg, o_variant_reg};
   int fail_count = 0, cmp_count = 0;
   always #20 i_mclk = ~i_mclk;
   operand_address_formation u_operand_address_formation (.i_mclk, .i_srst, .i_psel,
      .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
      .i_ext_valid, .i_ext_format, .i_ext_dup_a, .i_ext_has_variant, .i_ext_variant_exception,
      .i_ext_a_field, .i_ext_b_field, .i_ext_variant, .o_ext_ready, .o_ext_done, .o_slot_rd,
      .o_slot_addr, .i_slot_valid, .i_slot_data, .o_a_operand_address_reg,
      .o_b_operand_address_reg, .o_variant_reg, .o_halt, .o_address_violation_flag,
      .o_internal_interrupt);
   slot_memory u_slot_memory (.i_mclk, .i_srst, .i_rd(o_slot_rd), .i_addr(o_slot_addr),
      .i_wait(slot_wait), .o_valid(i_slot_valid), .o_data(i_slot_data));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do @(posedge i_mclk); while (o_pready !== 1'b1);
      rdata = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_mclk);
   endtask : apb
   task automatic ext(input logic [1:0] f, input logic [2:0] fl, input logic [23:0] a, b,
      input logic [5:0] v);
      {i_ext_dup_a, i_ext_has_variant, i_ext_variant_exception} <= fl;
      i_ext_format <= f;
      i_ext_a_field <= a;
      i_ext_b_field <= b;
      i_ext_variant <= v;
      i_ext_valid <= 1'b1;
      do @(posedge i_mclk); while (o_ext_ready !== 1'b1);
      i_ext_valid <= 1'b0;
      do @(posedge i_mclk); while (o_ext_done !== 1'b1 && o_halt !== 1'b1);
      irq = o_internal_interrupt;
   endtask : ext
   function automatic logic [18:0] form(input logic [23:0] f, input int w);
      logic [18:0] m, s, adr;
      logic [23:0] d;
      m = (19'h1 << w) - 19'h1;
      adr = {13'h0, f[22:19], 2'h0} + (f[23] ? {7'd3, 12'h0} : 19'h0);
      d = u_slot_memory.slot_value(adr);
      s = (f[22:19] == 4'h0) ? 19'h0 : d[18:0];
      return ((f[18:0] & m) + (s & m)) & m;
   endfunction : form
   task automatic chk_config();
      logic [19:0] cap [6] = '{20'h08000, 20'h08001, 20'h0C000, 20'h10001, 20'h20000, 20'h40000};
      logic [4:0] wid [6] = '{5'd15, 5'd16, 5'd16, 5'd17, 5'd17, 5'd18};
      apb(1'b0, REG_CAPACITY, 32'h0);
      `CHECK(rdata, 32'h00040000)
      apb(1'b0, 8'h40, 32'h0);
      `CHECK({rerr, rdata}, 33'h100000000)
      foreach (cap[k]) begin
         apb(1'b1, REG_CAPACITY, {12'h0, cap[k]});
         apb(1'b0, REG_STATUS, 32'h0);
         `CHECK(rdata[8:4], wid[k])
      end
      apb(1'b1, REG_CONFIG, 32'h2);
      apb(1'b0, REG_STATUS, 32'h0);
      `CHECK(rdata[8:4], 5'd19)
   endtask : chk_config
   task automatic chk_chain();
      apb(1'b1, REG_CONFIG, 32'h0);
      ext(FMT_AB, 3'b010, 24'd890, 24'd690, 6'h2A);
      `CHECK(regs, {19'd890, 19'd690, 6'h2A})
      ext(FMT_A, 3'b100, 24'd1234, 24'd0, 6'h0);
      `CHECK(regs, {19'd1234, 19'd1234, 6'h2A})
      ext(FMT_A, 3'b000, 24'd500, 24'd0, 6'h0);
      `CHECK(regs[43:6], {19'd500, 19'd1234})
      ext(FMT_NONE, 3'b010, 24'd7, 24'd7, 6'h15);
      `CHECK(regs, {19'd500, 19'd1234, 6'h15})
      ext(FMT_AB, 3'b001, 24'd1, 24'd2, 6'h0);
      `CHECK(o_variant_reg, 6'h00)
      apb(1'b1, REG_CONFIG, 32'h4);
      ext(FMT_NONE, 3'b010, 24'd0, 24'd0, 6'h11);
      ext(FMT_NONE, 3'b000, 24'd0, 24'd0, 6'h0);
      `CHECK(o_variant_reg, 6'h11)
      ext(FMT_A, 3'b000, 24'd9, 24'd0, 6'h0);
      `CHECK(o_variant_reg, 6'h00)
   endtask : chk_chain
   task automatic chk_index();
      logic [4:0] mods [5] = '{5'h01, 5'h0F, 5'h10, 5'h11, 5'h1F};
      logic [37:0] want;
      apb(1'b1, REG_CAPACITY, 32'h0C000);
      apb(1'b1, REG_CONFIG, 32'h30);
      foreach (mods[k]) begin
         slot_wait <= 2'(k);
         ext(FMT_AB, 3'b000, {mods[k], 19'd48000}, {mods[k], 19'd20}, 6'h0);
         want = {form({mods[k], 19'd48000}, 16), form({mods[k], 19'd20}, 16)};
         `CHECK(regs[43:6], want)
      end
      ext(FMT_AB, 3'b000, 24'd75000, 24'd65535, 6'h0);
      `CHECK(regs[43:6], {19'd9464, 19'd65535})
   endtask : chk_index
   task automatic chk_limits();
      apb(1'b1, REG_CONFIG, 32'h1);
      ext(FMT_AB, 3'b000, 24'd1000, 24'd50000, 6'h0);
      `CHECK({irq, o_address_violation_flag, regs[43:6]}, {2'b11, 19'd1000, 19'd65535})
      apb(1'b1, REG_STATUS, 32'h1);
      `CHECK(o_address_violation_flag, 1'b0)
      apb(1'b1, REG_CONFIG, 32'h2);
      ext(FMT_A, 3'b000, 24'd60000, 24'd0, 6'h0);
      `CHECK({o_halt, o_ext_ready, regs[43:25]}, {2'b10, 19'd1000})
      apb(1'b1, REG_STATUS, 32'h2);
      `CHECK({o_halt, o_ext_ready}, 2'b01)
   endtask : chk_limits
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (5) @(posedge i_mclk);
      i_srst <= 1'b0;
      chk_config();
      chk_chain();
      chk_index();
      chk_limits();
      complete_run();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #200000;
      fail_count++;
      complete_run();
   end
endmodule : test_operand_address_formation
bind operand_address_formation oaf_sva u_oaf_sva (.i_mclk, .i_srst, .i_psel, .i_penable,
   .i_pwrite, .o_pready, .i_ext_valid, .i_ext_format, .i_ext_dup_a, .i_ext_a_field,
   .i_ext_b_field, .o_ext_ready, .o_ext_done, .o_a_operand_address_reg,
   .o_b_operand_address_reg, .o_halt, .o_address_violation_flag, .o_internal_interrupt);

// [verilog/addr_former.sv]
// One operand address: index addition, wrap and capacity check
`timescale 1ns/100ps
module addr_former
   import oaf_pkg::*;
(
   // Address field and index slot contents
   input wire logic [FIELD_W-1:0] i_field,
   input wire logic [FIELD_W-1:0] i_slot,
   // Configuration
   input wire logic [ADDR_W-1:0] i_mask,
   input wire logic [ADDR_W:0] i_capacity,
   // Result
   output logic [ADDR_W-1:0] o_addr,
   output logic o_over_cap
);
   wire logic [MOD_W-1:0] modifier = i_field[FIELD_W-1:ADDR_W];
   wire logic indexed = (modifier != MOD_DIRECT) && (modifier != MOD_INDIRECT);
   // Only active bits of both operands take part [RULE1] [RULE2]
   wire logic [ADDR_W-1:0] base = i_field[ADDR_W-1:0] & i_mask;
   wire logic [ADDR_W-1:0] augment = indexed ? (i_slot[ADDR_W-1:0] & i_mask) : '0;
   wire logic [ADDR_W:0] sum = {1'b0, base} + {1'b0, augment};
   wire logic in_range = sum <= {1'b0, i_mask};
   // Wrap modulo 2**width [RULE8]
   assign o_addr = sum[ADDR_W-1:0] & i_mask;
   // Past installed memory yet inside the active range [RULE6] [RULE7]
   assign o_over_cap = in_range && (sum >= i_capacity);
endmodule : addr_former

// [verilog/operand_address_formation.sv]
// Operand address formation and chaining with APB configuration
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
// Contract
// [RULE1] Indexed address adds slot to field, active bits
// [RULE2] Addition width equals control register width
// [RULE3] Width 15/16/17/18 for 32K/64K/128K/256K
// [RULE4] Between sizes, larger size's width applies
// [RULE5] Top-end variant keeps all 19 bits
// [RULE6] Top-end, unprotected, over capacity halts processor
// [RULE7] Protected over capacity: flag, abort, interrupt
// [RULE8] Beyond active range addresses wrap around
// [RULE9] Format AB loads both operand registers
// [RULE10] Duplicate-A copies A into both registers
// [RULE11] Preserve-B loads A, leaves B alone
// [RULE12] No-address format reuses both registers
// [RULE13] Variant register loads instruction variant character
// [RULE14] Advanced: missing variant keeps register, exceptions aside
// [RULE15] Basic: addressed instruction destroys variant register
// [RULE16] Registers persist across instructions for chaining
// [RULE17] Modifier selects direct, indirect, low or protected slots
// [RULE18] Low slot n ends at location 4n
// [RULE19] Indexing happens in register, memory untouched
// [RULE20] Capacity, width, protection are configuration
module operand_address_formation
   import oaf_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Instruction extraction request
   input wire logic i_ext_valid,
   input wire logic [1:0] i_ext_format,
   input wire logic i_ext_dup_a,
   input wire logic i_ext_has_variant,
   input wire logic i_ext_variant_exception,
   input wire logic [FIELD_W-1:0] i_ext_a_field,
   input wire logic [FIELD_W-1:0] i_ext_b_field,
   input wire logic [CHAR_W-1:0] i_ext_variant,
   output logic o_ext_ready,
   output logic o_ext_done,
   // Index slot read from main memory
   output logic o_slot_rd,
   output logic [ADDR_W-1:0] o_slot_addr,
   input wire logic i_slot_valid,
   input wire logic [FIELD_W-1:0] i_slot_data,
   // Results and events
   output logic [ADDR_W-1:0] o_a_operand_address_reg,
   output logic [ADDR_W-1:0] o_b_operand_address_reg,
   output logic [CHAR_W-1:0] o_variant_reg,
   output logic o_halt,
   output logic o_address_violation_flag,
   output logic o_internal_interrupt
);
   oaf_state_t state, next_state;
   logic [31:0] config_reg;
   logic [ADDR_W:0] capacity;
   logic [FIELD_W-1:0] a_field, b_field;
   logic [1:0] format;
   logic dup_a, has_variant, variant_exception;
   logic [CHAR_W-1:0] variant_in;
   logic [ADDR_W-1:0] a_reg, b_reg;
   logic [CHAR_W-1:0] variant_reg;
   logic violation, halt, interrupt_pulse, done_pulse;
   logic [ADDR_W-1:0] formed_addr;
   logic over_cap;
   logic [31:0] status_word;

   // Configuration decode [RULE20]
   wire logic protect_en = config_reg[CFG_PROTECT];
   wire logic top_end = config_reg[CFG_TOP_END];
   wire logic basic_variant = config_reg[CFG_BASIC];
   wire logic [BANK_W-1:0] protect_bank = config_reg[CFG_BANK_LSB +: BANK_W];

   // Active width from installed capacity, rounding up to next size [RULE3] [RULE4] [RULE5]
   wire logic [WIDTH_W-1:0] active_width =
      top_end ? WIDTH_TOP :
      (capacity <= CAP_32K) ? WIDTH_32K :
      (capacity <= CAP_64K) ? WIDTH_64K :
      (capacity <= CAP_128K) ? WIDTH_128K : WIDTH_256K;
   // One mask bit per address bit, set below the active width [RULE2]
   wire logic [ADDR_W-1:0] active_mask;
   for (genvar bit_idx = 0; bit_idx < ADDR_W; bit_idx++) begin : g_mask
      assign active_mask[bit_idx] = WIDTH_W'(bit_idx) < active_width;
   end

   // Field under work and its modifier
   wire logic [FIELD_W-1:0] cur_field = (state == ST_B_FORM) ? b_field : a_field;
   wire logic [MOD_W-1:0] cur_mod = cur_field[FIELD_W-1:ADDR_W];
   // Indirect resolution is outside this block; such fields are taken as direct
   wire logic cur_indexed = (cur_mod != MOD_DIRECT) && (cur_mod != MOD_INDIRECT); // [RULE17]
   wire logic [3:0] slot_num = cur_mod[3:0];
   wire logic [ADDR_W-1:0] slot_offset = ADDR_W'(slot_num) << SLOT_SHIFT; // [RULE18]
   wire logic [ADDR_W-1:0] bank_base = ADDR_W'(protect_bank) << BANK_SHIFT;
   wire logic forming = (state == ST_A_FORM) || (state == ST_B_FORM);
   // A slot field waits for memory; its data is only good while valid stands
   wire logic field_ready = forming && (!cur_indexed || i_slot_valid);
   // Other variants leave an unprotected over-range address unchecked
   wire logic cap_check_en = protect_en || top_end; // [RULE6] [RULE7]
   wire logic error_hit = field_ready && over_cap && cap_check_en;
   wire logic take = (state == ST_IDLE) && i_ext_valid && !halt;
   wire logic done_event = (state == ST_FINISH) || error_hit;

   // One former serves both fields, A first and then B
   addr_former u_addr_former (
      .i_field(cur_field),
      .i_slot(i_slot_data),
      .i_mask(active_mask),
      .i_capacity(capacity),
      .o_addr(formed_addr),
      .o_over_cap(over_cap)
   );

   // Slot read: index slots are only read, never written [RULE19]
   assign o_slot_rd = forming && cur_indexed && !halt;
   assign o_slot_addr = cur_mod[MOD_W-1] ? (bank_base + slot_offset) : slot_offset; // [RULE17]

   // Sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take) begin
               if (i_ext_format == FMT_NONE) begin
                  next_state = ST_FINISH; // [RULE12]
               end else begin
                  next_state = ST_A_FORM;
               end
            end
         end
         ST_A_FORM: begin
            if (error_hit) begin
               next_state = ST_IDLE; // [RULE6] [RULE7]
            end else if (field_ready) begin
               next_state = (format == FMT_AB) ? ST_B_FORM : ST_FINISH;
            end
         end
         ST_B_FORM: begin
            if (error_hit) begin
               next_state = ST_IDLE;
            end else if (field_ready) begin
               next_state = ST_FINISH;
            end
         end
         ST_FINISH: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Instruction capture
   // Latched at the take, so the requester is free at once
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         a_field <= '0;
         b_field <= '0;
         format <= FMT_NONE;
         dup_a <= 1'b0;
         has_variant <= 1'b0;
         variant_exception <= 1'b0;
         variant_in <= '0;
      end else if (take) begin
         a_field <= i_ext_a_field;
         b_field <= i_ext_b_field;
         format <= i_ext_format;
         dup_a <= i_ext_dup_a;
         has_variant <= i_ext_has_variant;
         variant_exception <= i_ext_variant_exception;
         variant_in <= i_ext_variant;
      end
   end

   // Operand address registers hold between instructions [RULE16]
   // An abort skips the failing field and any field after it
   wire logic a_load = (state == ST_A_FORM) && field_ready && !error_hit;
   wire logic b_load = (state == ST_B_FORM) && field_ready && !error_hit;
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         a_reg <= '0;
         b_reg <= '0;
      end else begin
         if (a_load) begin
            a_reg <= formed_addr; // [RULE9] [RULE11]
         end
         if (a_load && format == FMT_A && dup_a) begin
            b_reg <= formed_addr; // [RULE10]
         end else if (b_load) begin
            b_reg <= formed_addr; // [RULE9]
         end
      end
   end

   // Variant register, updated as the instruction completes
   // An aborted instruction leaves it as it was
   wire logic addressed = (format != FMT_NONE);
   wire logic variant_clear =
      basic_variant ? addressed : variant_exception; // [RULE15] [RULE14]
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         variant_reg <= VARIANT_CLEARED;
      end else if (state == ST_FINISH) begin
         if (has_variant) begin
            variant_reg <= variant_in; // [RULE13]
         end else if (variant_clear) begin
            variant_reg <= VARIANT_CLEARED; // [RULE15]
         end
      end
   end

   // APB access
   wire logic apb_access = i_psel && i_penable;
   wire logic apb_wr = apb_access && i_pwrite;
   wire logic hit_config = i_paddr == REG_CONFIG;
   wire logic hit_capacity = i_paddr == REG_CAPACITY;
   wire logic hit_status = i_paddr == REG_STATUS;
   wire logic hit_a = i_paddr == REG_A_ADDR;
   wire logic hit_b = i_paddr == REG_B_ADDR;
   wire logic hit_var = i_paddr == REG_VARIANT;
   wire logic mapped = hit_config | hit_capacity | hit_status | hit_a | hit_b | hit_var;
   wire logic clr_violation = apb_wr && hit_status && i_pwdata[ST_VIOLATION];
   wire logic clr_halt = apb_wr && hit_status && i_pwdata[ST_HALT];
   wire logic set_violation = error_hit && protect_en; // [RULE7]
   wire logic set_halt = error_hit && !protect_en && top_end; // [RULE6]

   // Settings take effect on the access edge of the write
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         config_reg <= CONFIG_RST;
         capacity <= CAPACITY_RST;
      end else begin
         if (apb_wr && hit_config) begin
            config_reg <= i_pwdata;
         end
         if (apb_wr && hit_capacity) begin
            capacity <= i_pwdata[ADDR_W:0];
         end
      end
   end

   // Sticky flags and one-cycle event pulses; a new event beats a same-cycle clear
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         violation <= 1'b0;
         halt <= 1'b0;
         interrupt_pulse <= 1'b0;
         done_pulse <= 1'b0;
      end else begin
         violation <= set_violation | (violation & ~clr_violation);
         halt <= set_halt | (halt & ~clr_halt);
         interrupt_pulse <= set_violation; // [RULE7]
         done_pulse <= done_event;
      end
   end

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_VIOLATION] = violation;
      status_word[ST_HALT] = halt;
      status_word[ST_BUSY] = state != ST_IDLE;
      status_word[ST_WIDTH_LSB +: WIDTH_W] = active_width;
   end
   // Read data follows the address, so reads cost no wait state
   wire logic [31:0] capacity_word = {12'h000, capacity};
   wire logic [31:0] a_word = {13'h0000, a_reg};
   wire logic [31:0] b_word = {13'h0000, b_reg};
   wire logic [31:0] variant_word = {26'h0000000, variant_reg};
   assign o_prdata =
      hit_config ? config_reg :
      hit_capacity ? capacity_word :
      hit_status ? status_word :
      hit_a ? a_word :
      hit_b ? b_word :
      hit_var ? variant_word : 32'h0000_0000;
   assign o_pready = 1'b1;
   // Unmapped offsets answer with an error and change nothing
   assign o_pslverr = apb_access && !mapped;

   // A halt refuses new work until software clears it
   assign o_ext_ready = (state == ST_IDLE) && !halt;
   assign o_ext_done = done_pulse;
   assign o_a_operand_address_reg = a_reg;
   assign o_b_operand_address_reg = b_reg;
   assign o_variant_reg = variant_reg;
   assign o_halt = halt;
   assign o_address_violation_flag = violation;
   assign o_internal_interrupt = interrupt_pulse;
endmodule : operand_address_formation
